//--- logic/camd_decoder.sv
// camd_decoder: fetches one instruction, decodes its addressing mode and forms the address.
// assumes a byte-wide read port answered by mem_ack_i with data valid in that same cycle.
`timescale 1ns/1ns
module camd_decoder
    import camd_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        start_i,
    input  wire logic [15:0] pc_i,
    input  wire logic [7:0]  index_x_i,
    input  wire logic [7:0]  index_y_i,
    output logic             busy_o,
    output logic             mem_rd_o,
    output logic [15:0]      mem_addr_o,
    input  wire logic [7:0]  mem_rdata_i,
    input  wire logic        mem_ack_i,
    output logic             done_o,
    output logic             illegal_o,
    output logic [7:0]       prefix_o,
    output logic [7:0]       opcode_o,
    output logic [4:0]       mode_o,
    output logic [3:0]       class_o,
    output logic [2:0]       length_o,
    output logic [15:0]      next_pc_o,
    output logic [15:0]      eff_addr_o,
    output logic [7:0]       operand_o,
    output logic [15:0]      branch_target_o
);

    // ------------------------------------------------------------------
    // decode functions
    // ------------------------------------------------------------------
    function automatic camd_mode_t base_mode(input logic [7:0] op);
        unique case (op[7:4])
            GRP_BIT_REL:  base_mode = M_BITR_D;
            GRP_BIT:      base_mode = M_BIT_D;
            GRP_REL:      base_mode = M_REL_D;
            GRP_RMW_DIR,
            GRP_DIR_S:    base_mode = M_DIR_S;
            GRP_RMW_IDXS,
            GRP_IDX_S:    base_mode = M_IDX_S;
            GRP_RMW_IDX0,
            GRP_IDX_0:    base_mode = M_IDX_0;
            GRP_IMM:      base_mode = (op[3:0] == LO_CALL_REL) ? M_REL_D : M_IMM;
            GRP_DIR_L:    base_mode = M_DIR_L;
            GRP_IDX_L:    base_mode = M_IDX_L;
            default:      base_mode = M_INH;
        endcase
    endfunction

    // indirect forms selected by the indirect prefixes
    function automatic camd_mode_t to_indirect(input camd_mode_t m);
        unique case (m)
            M_DIR_S:  to_indirect = M_IND_S;
            M_DIR_L:  to_indirect = M_IND_L;
            M_IDX_S:  to_indirect = M_IIX_S;
            M_IDX_L:  to_indirect = M_IIX_L;
            M_REL_D:  to_indirect = M_REL_I;
            M_BIT_D:  to_indirect = M_BIT_I;
            M_BITR_D: to_indirect = M_BITR_I;
            default:  to_indirect = m;
        endcase
    endfunction

    // bytes following the opcode
    function automatic logic [1:0] follow_bytes(input camd_mode_t m);
        unique case (m)
            M_INH, M_IDX_0:                     follow_bytes = 2'h0;
            M_DIR_L, M_IDX_L, M_BITR_D, M_BITR_I: follow_bytes = 2'h2;
            default:                            follow_bytes = 2'h1;
        endcase
    endfunction

    // bytes of pointer read from memory
    function automatic logic [1:0] ptr_bytes(input camd_mode_t m);
        unique case (m)
            M_IND_L, M_IIX_L:                    ptr_bytes = 2'h2;
            M_IND_S, M_IIX_S, M_REL_I,
            M_BIT_I, M_BITR_I:                   ptr_bytes = 2'h1;
            default:                             ptr_bytes = 2'h0;
        endcase
    endfunction

    function automatic logic is_indexed(input camd_mode_t m);
        is_indexed = (m == M_IDX_0) || (m == M_IDX_S) || (m == M_IDX_L) || (m == M_IIX_S) || (m == M_IIX_L);
    endfunction

    function automatic logic is_long(input camd_mode_t m);
        is_long = (m == M_DIR_L) || (m == M_IDX_L) || (m == M_IND_L) || (m == M_IIX_L);
    endfunction

    // operation class from the opcode
    function automatic camd_class_t op_class(input logic [7:0] op);
        camd_class_t c;
        c = C_LOAD;
        unique case (op[7:4])
            GRP_BIT_REL:  c = C_BITJMP;
            GRP_BIT:      c = C_BIT;
            GRP_REL:      c = C_BRANCH;
            GRP_INH_0:    c = (op[3:0] < 4'h4) ? C_INTR : (op[3:0] < 4'h8) ? C_LOAD : C_STACK;
            GRP_INH_1:    c = (op[3:0] < 4'h8) ? C_LOAD : (op[3:0] < 4'hC) ? C_FLAG : C_JUMP;
            GRP_RMW_DIR, GRP_RMW_A, GRP_RMW_X, GRP_RMW_IDXS, GRP_RMW_IDX0: begin
                unique case (op[3:0])
                    4'h0, 4'h3:       c = C_LOGIC;
                    4'hA, 4'hC:       c = C_INCDEC;
                    4'hD:             c = C_CMP;
                    4'hF:             c = C_LOAD;
                    default:          c = C_SHIFT;
                endcase
            end
            default: begin
                unique case (op[3:0])
                    4'h1, 4'h3, 4'h5: c = C_CMP;
                    4'h4, 4'h8, 4'hA: c = C_LOGIC;
                    4'h0, 4'h2, 4'h9, 4'hB: c = C_ARITH;
                    4'hC, 4'hD:       c = C_JUMP;
                    default:          c = C_LOAD;
                endcase
            end
        endcase
        op_class = c;
    endfunction

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    camd_state_t state;
    logic [15:0] fetch_addr;
    logic [15:0] start_pc;
    logic [7:0]  byte1;
    logic [7:0]  byte2;
    logic [7:0]  ptr_hi;
    logic [7:0]  ptr_lo;
    logic [2:0]  len;
    camd_mode_t  mode;
    camd_class_t cls;
    logic        use_y;
    logic        bad;

    camd_mode_t  dec_mode;
    logic        dec_bad;
    logic [1:0]  n_follow;
    logic [1:0]  n_ptr;
    logic        is_prefix;
    logic        finish;
    logic        last_seen;

    assign is_prefix = (mem_rdata_i == SECOND_INDEX_PREFIX) || (mem_rdata_i == INDIRECT_PREFIX)
                     || (mem_rdata_i == SECOND_INDEX_INDIRECT_PREFIX);

    // mode and legality of the opcode arriving now, under the stored prefix
    always_comb begin
        camd_mode_t bm;
        camd_class_t oc;
        bm      = base_mode(mem_rdata_i);
        oc      = op_class(mem_rdata_i);
        dec_mode = bm;
        dec_bad  = 1'b0;
        if (prefix_o == INDIRECT_PREFIX) begin
            dec_mode = to_indirect(bm);
            dec_bad  = (to_indirect(bm) == bm);
        end else if (prefix_o == SECOND_INDEX_INDIRECT_PREFIX) begin
            dec_mode = to_indirect(bm);
            dec_bad  = !((bm == M_IDX_S) || (bm == M_IDX_L));
        end
        if ((bm == M_IMM) && !(oc inside {C_LOAD, C_CMP, C_LOGIC, C_ARITH})) begin
            dec_bad = 1'b1;
        end
        if (is_long(bm) && (oc inside {C_SHIFT, C_INCDEC, C_BIT, C_BITJMP})) begin
            dec_bad = 1'b1;
        end
    end

    assign n_follow = follow_bytes(mode);
    assign n_ptr    = ptr_bytes(mode);

    assign busy_o   = (state != S_IDLE);
    assign mem_rd_o = (state != S_IDLE);

    // ------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state <= S_IDLE;
        end else begin
            unique case (state)
                S_IDLE: if (start_i) state <= S_OPC;
                S_OPC: if (mem_ack_i && !(is_prefix && (prefix_o == 8'h00))) begin
                    state <= (follow_bytes(dec_mode) != 2'h0) ? S_B1
                           : (ptr_bytes(dec_mode) != 2'h0) ? S_PLO : S_IDLE;
                end
                S_B1: if (mem_ack_i) begin
                    state <= (n_follow == 2'h2) ? S_B2 : (n_ptr == 2'h2) ? S_PHI
                           : (n_ptr == 2'h1) ? S_PLO : S_IDLE;
                end
                S_B2: if (mem_ack_i) state <= (n_ptr != 2'h0) ? S_PLO : S_IDLE;
                S_PHI: if (mem_ack_i) state <= S_PLO;
                S_PLO: if (mem_ack_i) state <= S_IDLE;
            endcase
        end
    end

    // memory address: instruction stream, then pointer location
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            fetch_addr <= 16'h0000;
            mem_addr_o <= 16'h0000;
        end else if (state == S_IDLE) begin
            if (start_i) begin
                fetch_addr <= pc_i + ADDR_STEP;
                mem_addr_o <= pc_i;
            end
        end else if (mem_ack_i) begin
            fetch_addr <= fetch_addr + ADDR_STEP;
            mem_addr_o <= fetch_addr;
            if ((state == S_B1) && (n_ptr != 2'h0) && (n_follow == 2'h1)) begin
                mem_addr_o <= {PAGE_ZERO_HIGH, mem_rdata_i};
            end
            if ((state == S_B2) && (n_ptr != 2'h0)) begin
                mem_addr_o <= {PAGE_ZERO_HIGH, byte1};
            end
            if (state == S_OPC && follow_bytes(dec_mode) == 2'h0 && ptr_bytes(dec_mode) != 2'h0) begin
                mem_addr_o <= {PAGE_ZERO_HIGH, mem_rdata_i};
            end
            if (state == S_PHI) begin
                mem_addr_o <= mem_addr_o + ADDR_STEP;
            end
        end
    end

    // prefix, opcode, mode, class, length
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            prefix_o <= 8'h00;
            opcode_o <= 8'h00;
            mode     <= M_INH;
            cls      <= C_LOAD;
            len      <= 3'h0;
            start_pc <= 16'h0000;
            use_y    <= 1'b0;
            bad      <= 1'b0;
        end else if ((state == S_IDLE) && start_i) begin
            prefix_o <= 8'h00;
            len      <= 3'h0;
            start_pc <= pc_i;
            use_y    <= 1'b0;
            bad      <= 1'b0;
        end else if (mem_ack_i && (state inside {S_OPC, S_B1, S_B2})) begin
            len <= len + LEN_OPCODE;
            if (state == S_OPC) begin
                if (is_prefix && (prefix_o == 8'h00)) begin
                    prefix_o <= mem_rdata_i;
                end else begin
                    opcode_o <= mem_rdata_i;
                    mode     <= dec_mode;
                    cls      <= op_class(mem_rdata_i);
                    bad      <= dec_bad;
                    use_y    <= (prefix_o == SECOND_INDEX_PREFIX)
                             || (prefix_o == SECOND_INDEX_INDIRECT_PREFIX);
                end
            end
        end
    end

    // operand bytes and pointer bytes
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            byte1  <= 8'h00;
            byte2  <= 8'h00;
            ptr_hi <= 8'h00;
            ptr_lo <= 8'h00;
        end else if ((state == S_IDLE) && start_i) begin
            byte1  <= 8'h00;
            byte2  <= 8'h00;
            ptr_hi <= 8'h00;
            ptr_lo <= 8'h00;
        end else if (mem_ack_i) begin
            if (state == S_B1) byte1 <= mem_rdata_i;
            if (state == S_B2) byte2 <= mem_rdata_i;
            if (state == S_PHI) ptr_hi <= mem_rdata_i;
            if (state == S_PLO) ptr_lo <= mem_rdata_i;
        end
    end

    // ------------------------------------------------------------------
    // effective address and results
    // ------------------------------------------------------------------
    logic [15:0] index_w;
    logic [15:0] base_w;
    logic [15:0] ea;
    logic [7:0]  rel_off;
    logic [15:0] after_pc;

    assign index_w  = {PAGE_ZERO_HIGH, use_y ? index_y_i : index_x_i};
    assign after_pc = start_pc + {13'h0000, len};

    always_comb begin
        base_w  = 16'h0000;
        rel_off = byte1;
        unique case (mode)
            M_DIR_S, M_BIT_D, M_BITR_D: base_w = {PAGE_ZERO_HIGH, byte1};
            M_DIR_L, M_IDX_L:  base_w = {byte1, byte2};
            M_IDX_S:           base_w = {PAGE_ZERO_HIGH, byte1};
            M_IND_S, M_IIX_S, M_BIT_I, M_BITR_I: base_w = {PAGE_ZERO_HIGH, ptr_lo};
            M_IND_L, M_IIX_L:  base_w = {ptr_hi, ptr_lo};
            M_REL_I:           rel_off = ptr_lo;
            default:           base_w = 16'h0000;
        endcase
        if ((mode == M_BITR_D) || (mode == M_BITR_I)) begin
            rel_off = byte2;
        end
        ea = is_indexed(mode) ? (base_w + index_w) : base_w;
    end

    // results latch one cycle after the last byte is taken
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            done_o          <= 1'b0;
            illegal_o       <= 1'b0;
            mode_o          <= M_INH;
            class_o         <= C_LOAD;
            length_o        <= 3'h0;
            next_pc_o       <= 16'h0000;
            eff_addr_o      <= 16'h0000;
            operand_o       <= 8'h00;
            branch_target_o <= 16'h0000;
        end else begin
            done_o <= 1'b0;
            if (finish) begin
                done_o          <= 1'b1;
                illegal_o       <= bad;
                mode_o          <= mode;
                class_o         <= cls;
                length_o        <= len;
                next_pc_o       <= after_pc;
                eff_addr_o      <= ea;
                operand_o       <= (mode == M_IMM) ? byte1 : rel_off;
                branch_target_o <= after_pc + {{8{rel_off[7]}}, rel_off};
            end
        end
    end

    // one cycle after the last fetch the captured bytes are settled
    assign finish = last_seen;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            last_seen <= 1'b0;
        end else begin
            last_seen <= 1'b0;
            if (mem_ack_i) begin
                unique case (state)
                    S_OPC:  last_seen <= !(is_prefix && (prefix_o == 8'h00))
                                         && (follow_bytes(dec_mode) == 2'h0) && (ptr_bytes(dec_mode) == 2'h0);
                    S_B1:   last_seen <= (n_follow == 2'h1) && (n_ptr == 2'h0);
                    S_B2:   last_seen <= (n_ptr == 2'h0);
                    S_PLO:  last_seen <= 1'b1;
                    default: last_seen <= 1'b0;
                endcase
            end
        end
    end

endmodule

//--- logic/camd_pkg.sv
// camd_pkg: constants, mode codes and operation classes for the addressing-mode decoder.
// assumes a byte-wide memory read port and a single clock domain.
package camd_pkg;

    // ------------------------------------------------------------------
    // prefix bytes and sizes
    // ------------------------------------------------------------------
    localparam logic [7:0] SECOND_INDEX_PREFIX          = 8'h90;
    localparam logic [7:0] SECOND_INDEX_INDIRECT_PREFIX = 8'h91;
    localparam logic [7:0] INDIRECT_PREFIX              = 8'h92;
    localparam int         NUM_INSTRUCTIONS             = 63;
    localparam int         NUM_CLASSES                  = 13;
    localparam logic [7:0] PAGE_ZERO_HIGH               = 8'h00;
    localparam logic [2:0] LEN_OPCODE                   = 3'h1;
    localparam logic [15:0] ADDR_STEP                   = 16'h0001;

    // ------------------------------------------------------------------
    // opcode groups (high nibble), LO_CALL_REL (low nibble)
    // ------------------------------------------------------------------
    localparam logic [3:0] GRP_BIT_REL   = 4'h0;
    localparam logic [3:0] GRP_BIT       = 4'h1;
    localparam logic [3:0] GRP_REL       = 4'h2;
    localparam logic [3:0] GRP_RMW_DIR   = 4'h3;
    localparam logic [3:0] GRP_RMW_A     = 4'h4;
    localparam logic [3:0] GRP_RMW_X     = 4'h5;
    localparam logic [3:0] GRP_RMW_IDXS  = 4'h6;
    localparam logic [3:0] GRP_RMW_IDX0  = 4'h7;
    localparam logic [3:0] GRP_INH_0     = 4'h8;
    localparam logic [3:0] GRP_INH_1     = 4'h9;
    localparam logic [3:0] GRP_IMM       = 4'hA;
    localparam logic [3:0] GRP_DIR_S     = 4'hB;
    localparam logic [3:0] GRP_DIR_L     = 4'hC;
    localparam logic [3:0] GRP_IDX_L     = 4'hD;
    localparam logic [3:0] GRP_IDX_S     = 4'hE;
    localparam logic [3:0] GRP_IDX_0     = 4'hF;
    localparam logic [3:0] LO_CALL_REL   = 4'hD;

    // ------------------------------------------------------------------
    // addressing modes (17)
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        M_INH = 5'h00, M_IMM = 5'h01, M_DIR_S = 5'h02, M_DIR_L = 5'h03,
        M_IDX_0 = 5'h04, M_IDX_S = 5'h05, M_IDX_L = 5'h06, M_IND_S = 5'h07,
        M_IND_L = 5'h08, M_IIX_S = 5'h09, M_IIX_L = 5'h0A, M_REL_D = 5'h0B,
        M_REL_I = 5'h0C, M_BIT_D = 5'h0D, M_BIT_I = 5'h0E, M_BITR_D = 5'h0F,
        M_BITR_I = 5'h10
    } camd_mode_t;

    // ------------------------------------------------------------------
    // operation classes (13)
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        C_LOAD = 4'h0, C_STACK = 4'h1, C_INCDEC = 4'h2, C_CMP = 4'h3,
        C_LOGIC = 4'h4, C_BIT = 4'h5, C_BITJMP = 4'h6, C_ARITH = 4'h7,
        C_SHIFT = 4'h8, C_JUMP = 4'h9, C_BRANCH = 4'hA, C_INTR = 4'hB,
        C_FLAG = 4'hC
    } camd_class_t;

    // ------------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [5:0] {
        S_IDLE = 6'b000001, S_OPC = 6'b000010, S_B1 = 6'b000100,
        S_B2 = 6'b001000, S_PHI = 6'b010000, S_PLO = 6'b100000
    } camd_state_t;

endpackage

//--- test/camd_decoder_checker.sv
// checker: timing and result relations of the decoder ports
// assumes bound to camd_decoder, single clock, sync reset
`timescale 1ns/1ns
module camd_chk
    import camd_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        sys_rst_i,
    input wire logic        start_i,
    input wire logic [15:0] pc_i,
    input wire logic        busy_o,
    input wire logic        mem_rd_o,
    input wire logic [15:0] mem_addr_o,
    input wire logic        mem_ack_i,
    input wire logic        done_o,
    input wire logic [7:0]  prefix_o,
    input wire logic [7:0]  operand_o,
    input wire logic [4:0]  mode_o,
    input wire logic [2:0]  length_o,
    input wire logic [15:0] next_pc_o,
    input wire logic [15:0] eff_addr_o,
    input wire logic [15:0] branch_target_o
);
    logic [15:0] pc_q;
    logic [2:0]  pl;
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (start_i && !busy_o) begin
            pc_q <= pc_i;
        end
    end
    assign pl = (prefix_o != 8'h00) ? 3'h2 : 3'h1;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);
    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    AST_FIRST_ADDR: assert property (start_i && !busy_o |=> mem_rd_o && mem_addr_o == $past(pc_i))
        else $error("first fetch not at start address");
    AST_HOLD_ADDR: assert property (mem_rd_o && !mem_ack_i |=> $stable(mem_addr_o))
        else $error("read address moved without acknowledge");
    AST_DONE_END: assert property ($fell(busy_o) |-> ##1 done_o ##1 !done_o)
        else $error("done not a single pulse at end of fetch");
    AST_NEXT_PC: assert property (done_o |-> next_pc_o == pc_q + {13'h0000, length_o})
        else $error("next pc not start plus length");
    AST_INH_LEN: assert property (done_o && mode_o == M_INH |-> length_o == pl)
        else $error("inherent length wrong");
    AST_IMM_LEN: assert property (done_o && mode_o == M_IMM |-> length_o == pl + 3'h1)
        else $error("immediate length wrong");
    AST_LONG_LEN: assert property (done_o && mode_o inside {M_DIR_L, M_IDX_L} |-> length_o == pl + 3'h2)
        else $error("long form length wrong");
    AST_DIR_S: assert property (done_o && mode_o == M_DIR_S |-> eff_addr_o[15:8] == 8'h00 && length_o == pl + 3'h1)
        else $error("short direct out of page zero");
    AST_IDX0: assert property (done_o && mode_o == M_IDX_0 |-> eff_addr_o[15:8] == 8'h00 && length_o == pl)
        else $error("no-offset indexed wrong");
    AST_SHORT_SUM: assert property (done_o && mode_o inside {M_IDX_S, M_IIX_S} |-> eff_addr_o <= 16'h01FE)
        else $error("short indexed sum beyond range");
    AST_BRANCH: assert property (done_o && mode_o inside {M_REL_D, M_REL_I}
        |-> branch_target_o == next_pc_o + {{8{operand_o[7]}}, operand_o})
        else $error("relative target wrong");
endmodule
bind camd_decoder camd_chk i_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .start_i(start_i), .pc_i(pc_i),
    .busy_o(busy_o), .mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o), .mem_ack_i(mem_ack_i), .done_o(done_o),
    .prefix_o(prefix_o), .operand_o(operand_o), .mode_o(mode_o), .length_o(length_o),
    .next_pc_o(next_pc_o), .eff_addr_o(eff_addr_o), .branch_target_o(branch_target_o));

//--- test/camd_mem.sv
// memory model: 64 Kbyte byte-wide read port, prompt or random acknowledge
// assumes the bench preloads mem and picks the pace with slow_i
`timescale 1ns/1ns
module camd_mem (
    input  wire logic        clk_i,
    input  wire logic        slow_i,
    input  wire logic        rd_i,
    input  wire logic [15:0] addr_i,
    output logic             ack_o,
    output logic [7:0]       data_o
);
    logic [7:0] mem [65536];
    logic       go;
    always_ff @(posedge clk_i) go <= !slow_i || ($urandom_range(1) == 1);
    assign ack_o  = rd_i && go;
    // data only valid with ack: inverse otherwise
    assign data_o = ack_o ? mem[addr_i] : ~mem[addr_i];
endmodule

//--- test/cpu_addressing_mode_decoder_tb.sv
// testbench: decoder results against a reference built from the addressing rules
// assumes camd_mem answers reads; both paces are run
`timescale 1ns/1ns
module cpu_addressing_mode_decoder_tb import camd_pkg::*;;
    logic        clk_i = 0, sys_rst_i = 1, start_i = 0, slow = 0;
    logic [15:0] pc_i = 0;
    logic [7:0]  index_x_i = 0, index_y_i = 0;
    logic        busy_o, mem_rd_o, mem_ack_i, done_o, illegal_o;
    logic [15:0] mem_addr_o, next_pc_o, eff_addr_o, branch_target_o;
    logic [7:0]  mem_rdata_i, prefix_o, opcode_o, operand_o;
    logic [4:0]  mode_o;
    logic [3:0]  class_o;
    logic [2:0]  length_o;
    int          errors = 0, n_compared = 0;
    int          fol [17] = '{0, 1, 1, 2, 0, 1, 2, 1, 1, 1, 1, 1, 1, 1, 1, 2, 2};
    // {illegal, prefix, opcode, mode}
    logic [27:0] tab [28] = '{28'h0009D00, 28'h000A601, 28'h100AC01, 28'h000B602, 28'h0003C02,
        28'h000C603, 28'h000F604, 28'h090F604, 28'h0007C04, 28'h000E605, 28'h090E605, 28'h0006C05,
        28'h000D606, 28'h092B607, 28'h0923C07, 28'h092C608, 28'h092E609, 28'h091E609, 28'h092D60A,
        28'h091D60A, 28'h000270B, 28'h000AD0B, 28'h092270C, 28'h000100D, 28'h092100E, 28'h000000F,
        28'h0920010, 28'h191B602};
    camd_decoder i_dut (.clk_i, .sys_rst_i, .start_i, .pc_i, .index_x_i, .index_y_i, .busy_o, .mem_rd_o,
        .mem_addr_o, .mem_rdata_i, .mem_ack_i, .done_o, .illegal_o, .prefix_o, .opcode_o, .mode_o,
        .class_o, .length_o, .next_pc_o, .eff_addr_o, .operand_o, .branch_target_o);
    camd_mem i_mem (.clk_i, .slow_i(slow), .rd_i(mem_rd_o), .addr_i(mem_addr_o), .ack_o(mem_ack_i),
        .data_o(mem_rdata_i));
    initial forever #2 clk_i = ~clk_i;
    task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
        n_compared++;
        if (exp !== got) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ------------------------------------------------------------------
    // one instruction: place bytes, start, compare with reference
    // ------------------------------------------------------------------
    task automatic run(logic [27:0] e);
        logic [7:0]  pre, opc, b1, b2, x, y, ix, pb;
        logic [15:0] pc, pw;
        logic [4:0]  md;
        int          ln, ea, op, k;
        pre = e[23:16];
        opc = e[15:8];
        md = e[4:0];
        pc = 16'h0100 + 16'($urandom_range(16'hFE00));
        b1 = 8'($urandom_range(254));
        b2 = 8'($urandom);
        x = 8'($urandom);
        y = 8'($urandom);
        ix = (pre == SECOND_INDEX_PREFIX || pre == SECOND_INDEX_INDIRECT_PREFIX) ? y : x;
        ln = (pre != 8'h00) + 1 + fol[md];
        k = (pre != 8'h00);
        if (k == 1) i_mem.mem[pc] = pre;
        i_mem.mem[pc + 16'(k)] = opc;
        i_mem.mem[pc + 16'(k + 1)] = b1;
        i_mem.mem[pc + 16'(k + 2)] = b2;
        pb = i_mem.mem[{8'h00, b1}];
        pw = {pb, i_mem.mem[{8'h00, b1 + 8'h01}]};
        case (md)
            M_DIR_S, M_BIT_D, M_BITR_D: ea = b1;
            M_DIR_L: ea = {b1, b2};
            M_IDX_0: ea = ix;
            M_IDX_S: ea = b1 + ix;
            M_IDX_L: ea = {b1, b2} + ix;
            M_IND_S, M_BIT_I, M_BITR_I: ea = pb;
            M_IND_L: ea = pw;
            M_IIX_S: ea = pb + ix;
            M_IIX_L: ea = pw + ix;
            default: ea = -1;
        endcase
        op = (md == M_IMM || md == M_REL_D) ? b1 : (md == M_REL_I) ? pb : (md == M_BITR_D) ? b2 : -1;
        @(posedge clk_i);
        index_x_i <= x;
        index_y_i <= y;
        pc_i <= pc;
        start_i <= 1'b1;
        @(posedge clk_i);
        start_i <= 1'b0;
        for (k = 0; k < 60 && done_o !== 1'b1; k++) @(negedge clk_i);
        chk("done", 16'h0001, done_o);
        chk("illegal", e[24], illegal_o);
        chk("opcode", opc, opcode_o);
        if (md == M_IMM) chk("cls", 16'(!e[24]), 16'(class_o inside {C_LOAD, C_CMP, C_LOGIC, C_ARITH}));
        if (e[24] == 1'b0) begin
            chk("prefix", pre, prefix_o);
            chk("mode", md, mode_o);
            chk("length", 16'(ln), length_o);
            chk("next_pc", pc + 16'(ln), next_pc_o);
            if (ea >= 0) chk("eff_addr", 16'(ea), eff_addr_o);
            if (op >= 0) chk("operand", 16'(op), operand_o);
            if (op >= 0 && md != M_IMM) chk("target", pc + 16'(ln) + {{8{op[7]}}, op[7:0]}, branch_target_o);
        end
        $display("test %h %h finished", pre, opc);
    endtask
    initial begin
        void'($urandom(32'hFD36));
        for (int i = 0; i < 65536; i++) i_mem.mem[i] = 8'($urandom);
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        chk("busy_rst", 16'h0000, busy_o);
        chk("done_rst", 16'h0000, done_o);
        @(posedge clk_i);
        sys_rst_i <= 1'b0;
        for (int r = 0; r < 2; r++) begin
            slow <= r[0];
            foreach (tab[i]) run(tab[i]);
        end
        stop_test();
    end
    // watchdog: over thirty times the slow-pace run time
    initial begin
        #40000;
        errors++;
        stop_test();
    end
endmodule
